// ===== uart_defines.vh
`ifndef UART_DEFINES_VH
`define UART_DEFINES_VH
`define CLK_HZ 100000000
`define BAUD_1200 1200
`define BAUD_2400 2400
`define BAUD_4800 4800
`define BAUD_9600 9600
`define SEL_1200 2'h0
`define SEL_2400 2'h1
`define SEL_4800 2'h2
`define SEL_9600 2'h3
`define FMT_8N1 2'h0
`define FMT_7O1 2'h1
`define FMT_7E1 2'h2
`define FMT_7N2 2'h3
`define HS_NONE 2'h0
`define HS_SW_BOTH 2'h1
`define HS_SW_TX_HW_RX 2'h2
`define HS_HW_BOTH 2'h3
`define CHAR_XON 8'h11
`define CHAR_XOFF 8'h13
`define FRAME_BITS 4'ha
`define BUF_SIZE 9'h100
`define FREE_LOW 9'h040
`define FREE_HIGH 9'h0c0
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_TXDATA 8'h08
`define ADDR_RXDATA 8'h0c
`define ADDR_IRQ_STAT 8'h10
`define ADDR_IRQ_MASK 8'h14
`define CTRL_BAUD 1:0
`define CTRL_FMT 3:2
`define CTRL_HS 5:4
`define CTRL_RESET 6'h00
`define IRQ_RX_AVAIL 0
`define IRQ_OVERFLOW 1
`define IRQ_TX_TAKEN 2
`define IRQ_FRAME_ERR 3
`define IRQ_WIDTH 4
`endif

// ===== rs232_uart_flow_control.v
// Notes on behaviour
// - bit rate selectable among 1200, 2400, 4800, 9600 baud.
// - one start bit then seven or eight data bits.
// - parity even, odd or none per configured format.
// - frame ends with one or two stop bits.
// - receive buffer holds 256 bytes until command logic reads them.
// - resume character is 11h, pause character is 13h.
// - transmit data driven on output line, receive sampled on input.
// - handshake setting 0 none, 1 sw both, 2 sw tx/hw rx, 3 hw both.
// - software tx control halts on pause, continues on resume character.
// - without hardware control, rts held true and cts ignored.
// - hardware tx control stops sending while cts false.
// - hardware rx control drops rts at 3/4 full, raises at 1/4.
// - software rx control sends pause at 64 free, resume at 192 free.
// - bytes arriving with a full buffer are discarded.
// - storing resumes as soon as free space exists.
`timescale 1ns/100ps
`default_nettype none
`include "uart_defines.vh"
module rs232_uart_flow_control (
  input wire clock,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire [31:0] prdata,
  output wire pslverr,
  output wire irq,
  output wire txd,
  input wire rxd,
  output wire rts,
  input wire cts
);
  localparam [31:0] BIT_1200 = `CLK_HZ / `BAUD_1200;
  localparam [31:0] BIT_2400 = `CLK_HZ / `BAUD_2400;
  localparam [31:0] BIT_4800 = `CLK_HZ / `BAUD_4800;
  localparam [31:0] BIT_9600 = `CLK_HZ / `BAUD_9600;

  reg [5:0] ctrl_ff;
  reg [`IRQ_WIDTH-1:0] irqStat_ff;
  reg [`IRQ_WIDTH-1:0] irqMask_ff;
  reg pready_ff;
  reg [31:0] prdata_ff;
  reg rxdMeta_ff, rxdSync_ff, ctsMeta_ff, ctsSync_ff;
  reg [7:0] mem [0:255];
  reg [7:0] wrPtr_ff, rdPtr_ff;
  reg [8:0] count_ff;
  reg throttled_ff;
  reg pendXoff_ff, pendXon_ff;
  reg paused_ff;
  reg [7:0] hold_ff;
  reg holdFull_ff;
  reg [9:0] txShift_ff;
  reg [3:0] txBits_ff;
  reg [16:0] txCnt_ff;
  reg txActive_ff;
  reg rxActive_ff;
  reg [3:0] rxBits_ff;
  reg [16:0] rxCnt_ff;
  reg [9:0] rxShift_ff;
  reg rxDone_ff;

  wire [1:0] baudSel = ctrl_ff[`CTRL_BAUD];
  wire [1:0] fmt = ctrl_ff[`CTRL_FMT];
  wire [1:0] hsMode = ctrl_ff[`CTRL_HS];
  wire swTx = (hsMode == `HS_SW_BOTH) || (hsMode == `HS_SW_TX_HW_RX);
  wire hwTx = (hsMode == `HS_HW_BOTH);
  wire swRx = (hsMode == `HS_SW_BOTH);
  wire hwRx = (hsMode == `HS_SW_TX_HW_RX) || (hsMode == `HS_HW_BOTH);

  reg [16:0] bitLen;
  always @* begin
    case (baudSel)
      `SEL_1200: bitLen = BIT_1200[16:0];
      `SEL_2400: bitLen = BIT_2400[16:0];
      `SEL_4800: bitLen = BIT_4800[16:0];
      default: bitLen = BIT_9600[16:0];
    endcase
  end

  // apb: one wait state so read data comes from a flop
  wire apbAccess = psel && penable && !pready_ff;
  wire apbDone = psel && penable && pready_ff;
  wire wrEn = apbDone && pwrite;
  wire rdEn = apbDone && !pwrite;
  assign pready = pready_ff;
  assign prdata = prdata_ff;
  assign pslverr = 1'b0;

  wire [8:0] freeSpace = `BUF_SIZE - count_ff;
  wire bufEmpty = (count_ff == 9'h000);
  wire bufFull = (count_ff == `BUF_SIZE);

  reg [31:0] rdValue;
  always @* begin
    rdValue = 32'h00000000;
    if (paddr == `ADDR_CTRL) begin
      rdValue = {26'h0000000, ctrl_ff};
    end else if (paddr == `ADDR_STATUS) begin
      rdValue = {17'h00000, ctsSync_ff, rts, throttled_ff, paused_ff,
        txActive_ff, holdFull_ff, count_ff};
    end else if (paddr == `ADDR_RXDATA) begin
      rdValue = {23'h000000, bufEmpty, bufEmpty ? 8'h00 : mem[rdPtr_ff]};
    end else if (paddr == `ADDR_IRQ_STAT) begin
      rdValue = {28'h0000000, irqStat_ff};
    end else if (paddr == `ADDR_IRQ_MASK) begin
      rdValue = {28'h0000000, irqMask_ff};
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
      ctrl_ff <= `CTRL_RESET;
      irqMask_ff <= {`IRQ_WIDTH{1'b0}};
    end else begin
      pready_ff <= apbAccess;
      if (apbAccess) begin
        prdata_ff <= pwrite ? 32'h00000000 : rdValue;
      end
      if (wrEn && paddr == `ADDR_CTRL) begin
        ctrl_ff <= pwdata[5:0];
      end
      if (wrEn && paddr == `ADDR_IRQ_MASK) begin
        irqMask_ff <= pwdata[`IRQ_WIDTH-1:0];
      end
    end
  end

  // pin inputs through two flops before any use
  always @(posedge clock) begin
    if (rst) begin
      rxdMeta_ff <= 1'b1;
      rxdSync_ff <= 1'b1;
      ctsMeta_ff <= 1'b0;
      ctsSync_ff <= 1'b0;
    end else begin
      rxdMeta_ff <= rxd;
      rxdSync_ff <= rxdMeta_ff;
      ctsMeta_ff <= cts;
      ctsSync_ff <= ctsMeta_ff;
    end
  end

  // receiver: one sample at mid-bit, ten bits in every format
  wire rxTick = rxActive_ff && (rxCnt_ff == 17'h00000);
  always @(posedge clock) begin
    if (rst) begin
      rxActive_ff <= 1'b0;
      rxBits_ff <= 4'h0;
      rxCnt_ff <= 17'h00000;
      rxShift_ff <= 10'h3ff;
      rxDone_ff <= 1'b0;
    end else begin
      rxDone_ff <= 1'b0;
      if (!rxActive_ff) begin
        if (!rxdSync_ff) begin
          rxActive_ff <= 1'b1;
          rxCnt_ff <= {1'b0, bitLen[16:1]};
          rxBits_ff <= 4'h0;
        end
      end else if (rxTick) begin
        rxShift_ff <= {rxdSync_ff, rxShift_ff[9:1]};
        rxCnt_ff <= bitLen - 17'h00001;
        rxBits_ff <= rxBits_ff + 4'h1;
        // glitch shorter than half a bit is not a start
        if (rxBits_ff == 4'h0 && rxdSync_ff) begin
          rxActive_ff <= 1'b0;
        end else if (rxBits_ff == `FRAME_BITS - 4'h1) begin
          rxActive_ff <= 1'b0;
          rxDone_ff <= 1'b1;
        end
      end else begin
        rxCnt_ff <= rxCnt_ff - 17'h00001;
      end
    end
  end

  reg [7:0] rxByte;
  reg rxBad;
  always @* begin
    rxByte = {1'b0, rxShift_ff[7:1]};
    rxBad = !rxShift_ff[9];
    case (fmt)
      `FMT_8N1: rxByte = rxShift_ff[8:1];
      `FMT_7O1: rxBad = rxBad || !(^rxShift_ff[8:1]);
      `FMT_7E1: rxBad = rxBad || (^rxShift_ff[8:1]);
      default: rxBad = rxBad || !rxShift_ff[8];
    endcase
  end

  wire rxGood = rxDone_ff && !rxBad;
  wire isXoff = (rxByte == `CHAR_XOFF);
  wire isXon = (rxByte == `CHAR_XON);
  wire flowChar = swTx && (isXoff || isXon);
  wire pushReq = rxGood && !flowChar;
  wire push = pushReq && !bufFull;
  wire pop = rdEn && (paddr == `ADDR_RXDATA) && !bufEmpty;

  always @(posedge clock) begin
    if (push) begin
      mem[wrPtr_ff] <= rxByte;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      wrPtr_ff <= 8'h00;
      rdPtr_ff <= 8'h00;
      count_ff <= 9'h000;
      paused_ff <= 1'b0;
    end else begin
      if (push) begin
        wrPtr_ff <= wrPtr_ff + 8'h01;
      end
      if (pop) begin
        rdPtr_ff <= rdPtr_ff + 8'h01;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 9'h001;
      end else if (pop && !push) begin
        count_ff <= count_ff - 9'h001;
      end
      if (!swTx) begin
        paused_ff <= 1'b0;
      end else if (rxGood && isXoff) begin
        paused_ff <= 1'b1;
      end else if (rxGood && isXon) begin
        paused_ff <= 1'b0;
      end
    end
  end

  // receive throttle with hysteresis between 64 and 192 free bytes
  wire goThrottle = !throttled_ff && (freeSpace <= `FREE_LOW);
  wire goRelease = throttled_ff && (freeSpace >= `FREE_HIGH);
  assign rts = hwRx ? !throttled_ff : 1'b1;

  // transmitter
  wire txBlocked = (swTx && paused_ff) || (hwTx && !ctsSync_ff);
  wire sendFlow = pendXoff_ff || pendXon_ff;
  wire txStart = !txActive_ff && (sendFlow || (holdFull_ff && !txBlocked));
  wire [7:0] txByte = pendXoff_ff ? `CHAR_XOFF :
    (pendXon_ff ? `CHAR_XON : hold_ff);
  wire takeHold = txStart && !sendFlow;
  wire holdWrite = wrEn && (paddr == `ADDR_TXDATA) && !holdFull_ff;

  reg [9:0] txFrame;
  always @* begin
    case (fmt)
      `FMT_8N1: txFrame = {1'b1, txByte, 1'b0};
      `FMT_7O1: txFrame = {1'b1, ~^txByte[6:0], txByte[6:0], 1'b0};
      `FMT_7E1: txFrame = {1'b1, ^txByte[6:0], txByte[6:0], 1'b0};
      default: txFrame = {2'h3, txByte[6:0], 1'b0};
    endcase
  end

  assign txd = txShift_ff[0];

  always @(posedge clock) begin
    if (rst) begin
      throttled_ff <= 1'b0;
      pendXoff_ff <= 1'b0;
      pendXon_ff <= 1'b0;
      hold_ff <= 8'h00;
      holdFull_ff <= 1'b0;
      txShift_ff <= 10'h3ff;
      txBits_ff <= 4'h0;
      txCnt_ff <= 17'h00000;
      txActive_ff <= 1'b0;
    end else begin
      if (goThrottle) begin
        throttled_ff <= 1'b1;
      end else if (goRelease) begin
        throttled_ff <= 1'b0;
      end
      // a newer flow event supersedes one not yet sent
      if (swRx && goThrottle) begin
        pendXoff_ff <= 1'b1;
        pendXon_ff <= 1'b0;
      end else if (swRx && goRelease) begin
        pendXon_ff <= 1'b1;
        pendXoff_ff <= 1'b0;
      end else if (txStart && pendXoff_ff) begin
        pendXoff_ff <= 1'b0;
      end else if (txStart && pendXon_ff) begin
        pendXon_ff <= 1'b0;
      end
      if (holdWrite) begin
        hold_ff <= pwdata[7:0];
        holdFull_ff <= 1'b1;
      end else if (takeHold) begin
        holdFull_ff <= 1'b0;
      end
      if (txStart) begin
        txShift_ff <= txFrame;
        txActive_ff <= 1'b1;
        txBits_ff <= 4'h0;
        txCnt_ff <= bitLen - 17'h00001;
      end else if (txActive_ff) begin
        if (txCnt_ff == 17'h00000) begin
          txShift_ff <= {1'b1, txShift_ff[9:1]};
          txCnt_ff <= bitLen - 17'h00001;
          txBits_ff <= txBits_ff + 4'h1;
          if (txBits_ff == `FRAME_BITS - 4'h1) begin
            txActive_ff <= 1'b0;
          end
        end else begin
          txCnt_ff <= txCnt_ff - 17'h00001;
        end
      end
    end
  end

  // interrupts: set beats a simultaneous write-one clear
  wire [`IRQ_WIDTH-1:0] irqSet;
  wire [`IRQ_WIDTH-1:0] irqClr;
  assign irqSet[`IRQ_RX_AVAIL] = push;
  assign irqSet[`IRQ_OVERFLOW] = pushReq && bufFull;
  assign irqSet[`IRQ_TX_TAKEN] = takeHold;
  assign irqSet[`IRQ_FRAME_ERR] = rxDone_ff && rxBad;
  assign irqClr = (wrEn && paddr == `ADDR_IRQ_STAT) ?
    pwdata[`IRQ_WIDTH-1:0] : {`IRQ_WIDTH{1'b0}};
  always @(posedge clock) begin
    if (rst) begin
      irqStat_ff <= {`IRQ_WIDTH{1'b0}};
    end else begin
      irqStat_ff <= (irqStat_ff & ~irqClr) | irqSet;
    end
  end
  assign irq = |(irqStat_ff & irqMask_ff);
endmodule // rs232_uart_flow_control
`default_nettype wire

// ===== uart_flow_chk.sv
`timescale 1ns/100ps
`default_nettype none
module uart_flow_chk #(parameter int BIT = 10416) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic txd,
  input wire logic rxd,
  input wire logic rts,
  input wire logic cts
);
  // bit clock position inside a tx frame, valid at one rate only
  int fc_ff;
  logic txdOld_ff;
  always @(posedge clock) begin
    txdOld_ff <= txd;
    if (rst) fc_ff <= 0;
    else if (fc_ff != 0) fc_ff <= (fc_ff == 9*BIT+BIT/2) ? 0 : fc_ff + 1;
    else if (txdOld_ff && !txd) fc_ff <= 1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_no_slverr: assert property (psel |-> !pslverr)
    else $error("unexpected slave error");
  a_unmapped_zero: assert property (pready && !pwrite && paddr == 8'h18
    |-> prdata == 32'h0) else $error("unmapped read not zero");
  a_idle_mark: assert property ($fell(rst) |-> txd [*3])
    else $error("line not idle after reset");
  a_rts_reset: assert property ($fell(rst) |-> rts)
    else $error("rts false after reset");
  a_irq_reset: assert property ($fell(rst) |-> !irq)
    else $error("irq high after reset");
  a_start_low: assert property (fc_ff == BIT/2 |-> !txd)
    else $error("start bit not low");
  a_stop_mark: assert property (fc_ff == 9*BIT+BIT/2 |-> txd)
    else $error("stop bit not at mark");
  c_write: cover property (psel && penable && pwrite && pready);
  c_read: cover property (psel && penable && !pwrite && pready);
  c_frame: cover property (fc_ff == 9*BIT+BIT/2);
endmodule // uart_flow_chk
bind rs232_uart_flow_control uart_flow_chk uart_flow_chk_i (.clock, .rst,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
  .irq, .txd, .rxd, .rts, .cts);
`default_nettype wire

// ===== pc_host.sv
`timescale 1ns/100ps
`default_nettype none
module pc_host #(parameter int BIT = 10416) (
  input wire logic clock,
  input wire logic txd,
  input wire logic rts,
  output var logic rxd,
  output var logic cts
);
  logic [7:0] lastRx;
  int rxCount;
  initial begin
    rxd = 1'b1;
    cts = 1'b1;
    rxCount = 0;
  end
  // same rate and 8N1 as the device is set to
  task automatic sendByte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    while (rts !== 1'b1) @(posedge clock);
    for (int i = 0; i < 10; i++) begin
      @(posedge clock);
      rxd <= f[i];
      repeat (BIT - 1) @(posedge clock);
    end
  endtask
  // mid-bit sampling, lsb first
  always begin
    @(negedge txd);
    repeat (BIT/2) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clock);
      lastRx[i] = txd;
    end
    repeat (BIT) @(posedge clock);
    if (txd) rxCount++;
  end
endmodule // pc_host
`default_nettype wire

// ===== rs232_uart_flow_control_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "uart_defines.vh"
module rs232_uart_flow_control_test;
  logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  wire logic pready, pslverr, irq, txd, rxd, rts, cts;
  wire logic [31:0] prdata;
  int numErrors = 0, testsRun = 0, n;
  always #5 clock = ~clock;
  rs232_uart_flow_control rs232_uart_flow_control_i (.clock, .rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .irq,
    .txd, .rxd, .rts, .cts);
  pc_host pc_host_i (.clock, .txd, .rts, .rxd, .cts);
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      numErrors++;
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // watchdog, tx and rx frames overlap, about 105000 cycles
  initial begin
    repeat (130000) @(posedge clock);
    numErrors++;
    test_done;
  end
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    apb(1'b0, `ADDR_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk(rd, 32'h6000);
    apb(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h0);
    $display("test registers done");
    pc_host_i.cts <= 1'b0;
    apb(1'b1, `ADDR_IRQ_MASK, 32'h4);
    apb(1'b1, `ADDR_CTRL, 32'h33);
    apb(1'b0, `ADDR_CTRL, 32'h0);
    chk(rd, 32'h33);
    apb(1'b1, `ADDR_TXDATA, 32'ha5);
    n = 0;
    repeat (300) @(posedge clock) if (txd !== 1'b1) n++;
    chk(n, 0);
    chk({31'h0, irq}, 32'h0);
    pc_host_i.cts <= 1'b1;
    fork
      pc_host_i.sendByte(8'h13);
      begin
        n = 0;
        while (irq !== 1'b1 && n < 100) @(posedge clock) n++;
        chk({31'h0, irq}, 32'h1);
        while (pc_host_i.rxCount < 1 && n < 120000) @(posedge clock) n++;
        chk({24'h0, pc_host_i.lastRx}, 32'ha5);
      end
    join
    $display("test transmit done");
    n = 0;
    rd = 32'h0;
    while (rd[8:0] == 9'h0 && n < 2000) begin
      apb(1'b0, `ADDR_STATUS, 32'h0);
      n++;
    end
    chk({23'h0, rd[8:0]}, 32'h1);
    apb(1'b0, `ADDR_IRQ_STAT, 32'h0);
    chk(rd, 32'h5);
    apb(1'b1, `ADDR_IRQ_STAT, 32'h4);
    @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, `ADDR_RXDATA, 32'h0);
    chk(rd, 32'h13);
    apb(1'b0, `ADDR_RXDATA, 32'h0);
    chk(rd, 32'h100);
    $display("test receive done");
    apb(1'b1, `ADDR_CTRL, 32'h3);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk({31'h0, rd[13]}, 32'h1);
    $display("test mode zero done");
    test_done;
  end
endmodule // rs232_uart_flow_control_test
`default_nettype wire
